// *** design/dgps_pkg.sv ***
// constants, types and helpers shared by the gap/preamble sequencer
package dgps_pkg;

    // ********************************************
    // register map
    // ********************************************
    localparam logic [11:0] DGPS_ADDR_OFS = 12'h000;
    localparam logic [11:0] DGPS_STATUS_OFS = 12'h004;
    localparam int DGPS_SECTOR_W = 6;
    localparam logic [5:0] DGPS_SECTOR_RST = 6'h00;

    // status field positions
    localparam int ST_NEW_ADDR = 0;
    localparam int ST_GAP_DATA = 1;
    localparam int ST_TOGGLE = 2;
    localparam int ST_TERM = 3;
    localparam int ST_READ_EN = 4;
    localparam int ST_CONNECTED = 5;
    localparam int ST_ERROR = 6;
    localparam int ST_PH_READ = 7;
    localparam int ST_PH_WRITE = 8;
    localparam int ST_COUNT_LSB = 16;

    // ********************************************
    // disc clock counts
    // ********************************************
    localparam logic [8:0] GAP_LAST_COUNT = 9'h00C;
    localparam logic [8:0] READ_EN_COUNT = 9'h002;
    localparam logic [8:0] TOGGLE_LIMIT = 9'h008;
    localparam logic [8:0] PREAMBLE_END_COUNT = 9'h009;
    localparam logic [8:0] DATA_LAST_COUNT = 9'h17F;
    localparam logic [8:0] WRITE_PHASE_PULSES = 9'h196;
    localparam logic [8:0] READ_PHASE_PULSES = 9'h196;
    localparam int TRACKS = 4;
    localparam int CHAR_W = 7;

    // ********************************************
    // types
    // ********************************************
    typedef enum logic [2:0]
    {
        PH_ZERO = 3'b001,
        PH_READ = 3'b010,
        PH_WRITE = 3'b100
    } dgps_phase_t;

    typedef struct packed
    {
        dgps_phase_t phase;
        logic new_address_flag;
        logic gap_data_flag;
        logic preamble_toggle;
        logic termination_flag;
        logic read_enable_flag;
        logic channel_connected;
        logic error_flag;
        logic [5:0] sector;
        logic [8:0] phase_cnt;
        logic read_enable_out;
        logic phase_bit_read;
        logic phase_bit_write;
        logic data_request;
        logic [3:0] write_data_lines;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dgps_state_t;

    // mod-3 stage plus three times the character stage
    function automatic logic [8:0] count_value(logic [1:0] m, logic [6:0] c);
        return 9'(c) * 9'h003 + 9'(m);
    endfunction

endpackage

// *** design/dgps_gap_counter.sv ***
// modulo-three stage feeding a seven-bit character stage
`timescale 1ns/1ps
module dgps_gap_counter
    import dgps_pkg::*;
#(
    parameter int CW = CHAR_W
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic counter_clear,
    input wire logic advance,
    input wire logic counter_wrap_inhibit,
    // count
    output logic [1:0] mod_r,
    output logic [CW-1:0] char_r
);

    logic [1:0] mod_nxt;
    logic [CW-1:0] char_nxt;

    always_comb
    begin
        mod_nxt = mod_r;
        char_nxt = char_r;
        if (counter_clear || counter_wrap_inhibit)
        begin
            mod_nxt = 2'h0;
            char_nxt = '0;
        end
        else if (advance)
        begin
            if (mod_r == 2'h2)
            begin
                mod_nxt = 2'h0;
                char_nxt = char_r + 1'b1;
            end
            else
            begin
                mod_nxt = mod_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mod_r <= 2'h0;
            char_r <= '0;
        end
        else
        begin
            mod_r <= mod_nxt;
            char_r <= char_nxt;
        end
    end

endmodule

// *** design/dgps_track_writer.sv ***
// per-track write flip-flops mixing data with the clock track
`timescale 1ns/1ps
module dgps_track_writer
    import dgps_pkg::*;
#(
    parameter int NT = TRACKS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // clock track
    input wire logic clock_track_amp,
    input wire logic clock_cell_phase,
    input wire logic write_enable,
    // data
    input wire logic [NT-1:0] write_data_lines,
    output logic [NT-1:0] track_write_flop
);

    genvar i;
    generate
        for (i = 0; i < NT; i++)
        begin : g_trk
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    track_write_flop[i] <= 1'b0;
                end
                else if (write_enable && clock_track_amp && (clock_cell_phase || write_data_lines[i])) // [R14]
                begin
                    track_write_flop[i] <= ~track_write_flop[i];
                end
            end
        end
    endgenerate

endmodule

// *** design/dgps_sequencer.sv ***
// leading gap, channel check and write preamble sequencer with APB registers
// Operation
// R1: count a 13-pulse leading gap after sector
// R2: counters held cleared in phase zero, flag clear
// R3: counting only on pulses gated by gap flag; code also counts write-phase pulses after the preamble with gap flag clear
// R4: third gap pulse sets read enable
// R5: channel connects before the leading gap ends
// R6: connect command with unit address sets connected
// R7: thirteenth gap count clears gap/data flag
// R8: gap end enters read or write by direction
// R9: write entry clears read enable
// R10: dropped unit address clears connected outside gap/preamble; code clears it only while new address flag is clear, not in read phase
// R11: write phase lasts 406 disc pulses
// R12: protected band aborts write in one pulse
// R13: preamble 0101010100 on all four tracks
// R14: track flop toggles clock cells, data ones
// R15: preamble bit is gated every-other-count toggle
// R16: first write pulse sets gap flag, enables count
// R17: preamble ends when counter reaches nine
// R18: counter forced to zero at preamble end
// R19: first data bits come from shift register
// R20: two flags encode the sequence state
// R21: flags re-initialised at end of leading gap
// R22: counter is mod-three plus seven-bit stage
// R23: gap flag set on sector match in window
// R24: updates on disc clock, clears override counting
// R25: protect abort writes no preamble bits
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module dgps_sequencer
    import dgps_pkg::*;
#(
    parameter int NT = TRACKS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // disc timing and sector search
    input wire logic disc_clk_pulse,
    input wire logic clock_track_amp,
    input wire logic clock_cell_phase,
    input wire logic compare_window,
    input wire logic [5:0] current_sector,
    // channel
    input wire logic buffer_connect_command,
    input wire logic cmd_unit_match,
    input wire logic unit_address_on_channel,
    input wire logic direction_bit,
    input wire logic [NT-1:0] output_shift_bits,
    output logic data_request,
    output logic channel_connected,
    output logic error_flag,
    // selection unit
    input wire logic band_write_locked,
    output logic read_enable,
    output logic phase_bit_read,
    output logic phase_bit_write,
    output logic [NT-1:0] write_data_lines,
    output logic [NT-1:0] track_write_flop
);

    // ********************************************
    // state and counter
    // ********************************************
    dgps_state_t s_r;
    dgps_state_t s_nxt;
    logic [1:0] mod_r;
    logic [6:0] char_r;
    logic [8:0] cnt;
    logic phase_zero;
    logic in_write;
    logic in_read;
    logic counter_clear;
    logic gated_count_clock;
    logic counter_wrap_inhibit;
    logic gap_end_go;
    logic preamble_end;
    logic toggle_gate;
    logic data_time;
    logic apb_setup;
    logic apb_write;
    logic [31:0] status_word;

    assign cnt = count_value(mod_r, char_r);
    assign phase_zero = (s_r.phase == PH_ZERO);
    assign in_write = (s_r.phase == PH_WRITE);
    assign in_read = (s_r.phase == PH_READ);
    assign counter_clear = !s_r.gap_data_flag && (phase_zero || s_r.new_address_flag); // [R2] [R24]
    assign gated_count_clock = disc_clk_pulse
        && (s_r.gap_data_flag || (in_write && !s_r.new_address_flag)); // [R3] [R16]
    assign preamble_end = in_write && s_r.new_address_flag && s_r.gap_data_flag
        && (cnt == PREAMBLE_END_COUNT);
    assign counter_wrap_inhibit = disc_clk_pulse && preamble_end; // [R18]
    assign gap_end_go = phase_zero && s_r.gap_data_flag && (cnt == GAP_LAST_COUNT) && s_r.channel_connected;
    assign toggle_gate = s_r.new_address_flag && s_r.gap_data_flag && (cnt < TOGGLE_LIMIT);
    assign data_time = !s_r.new_address_flag && s_r.gap_data_flag; // [R20]

    dgps_gap_counter #(
        .CW(CHAR_W)
    ) u_cnt (
        .clk_sys(clk_sys),
        .rst(rst),
        .counter_clear(counter_clear),
        .advance(gated_count_clock),
        .counter_wrap_inhibit(counter_wrap_inhibit),
        .mod_r(mod_r),
        .char_r(char_r)
    ); // [R22]

    dgps_track_writer #(
        .NT(NT)
    ) u_trk (
        .clk_sys(clk_sys),
        .rst(rst),
        .clock_track_amp(clock_track_amp),
        .clock_cell_phase(clock_cell_phase),
        .write_enable(s_r.phase_bit_write),
        .write_data_lines(s_r.write_data_lines),
        .track_write_flop(track_write_flop)
    );

    // ********************************************
    // apb decode
    // ********************************************
    assign apb_setup = psel && !penable && !s_r.pready;
    assign apb_write = psel && penable && s_r.pready && pwrite && !s_r.pslverr && (paddr == DGPS_ADDR_OFS);

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_NEW_ADDR] = s_r.new_address_flag;
        status_word[ST_GAP_DATA] = s_r.gap_data_flag;
        status_word[ST_TOGGLE] = s_r.preamble_toggle;
        status_word[ST_TERM] = s_r.termination_flag;
        status_word[ST_READ_EN] = s_r.read_enable_flag;
        status_word[ST_CONNECTED] = s_r.channel_connected;
        status_word[ST_ERROR] = s_r.error_flag;
        status_word[ST_PH_READ] = s_r.phase_bit_read;
        status_word[ST_PH_WRITE] = s_r.phase_bit_write;
        status_word[ST_COUNT_LSB +: 9] = cnt;
    end

    // ********************************************
    // sequencing
    // ********************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (apb_setup)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            if (paddr == DGPS_ADDR_OFS)
            begin
                s_nxt.prdata[DGPS_SECTOR_W-1:0] = s_r.sector;
            end
            else if (paddr == DGPS_STATUS_OFS)
            begin
                s_nxt.prdata = status_word;
            end
            else
            begin
                s_nxt.pslverr = 1'b1;
            end
        end
        if (disc_clk_pulse)
        begin
            unique case (s_r.phase)
                PH_ZERO:
                begin
                    if (compare_window && s_r.new_address_flag && !s_r.gap_data_flag
                        && (current_sector == s_r.sector))
                    begin
                        s_nxt.gap_data_flag = 1'b1; // [R23]
                    end
                    if (s_r.gap_data_flag && (cnt == READ_EN_COUNT))
                    begin
                        s_nxt.read_enable_flag = 1'b1; // [R4]
                    end
                    if (buffer_connect_command && cmd_unit_match)
                    begin
                        s_nxt.channel_connected = 1'b1; // [R6]
                        s_nxt.error_flag = 1'b0;
                    end
                    if (s_r.gap_data_flag && (cnt == GAP_LAST_COUNT))
                    begin
                        s_nxt.gap_data_flag = 1'b0; // [R1] [R7] [R21]
                        s_nxt.preamble_toggle = 1'b0;
                        s_nxt.termination_flag = 1'b0;
                        if (gap_end_go && unit_address_on_channel)
                        begin
                            s_nxt.phase_cnt = 9'h000;
                            if (direction_bit)
                            begin
                                s_nxt.phase = PH_WRITE; // [R8]
                                s_nxt.read_enable_flag = 1'b0; // [R9]
                            end
                            else
                            begin
                                s_nxt.phase = PH_READ; // [R8]
                            end
                        end
                    end
                end
                PH_WRITE:
                begin
                    s_nxt.phase_cnt = s_r.phase_cnt + 9'h001;
                    if (s_r.new_address_flag && !s_r.gap_data_flag)
                    begin
                        if (band_write_locked)
                        begin
                            s_nxt.error_flag = 1'b1; // [R12] [R25]
                            s_nxt.channel_connected = 1'b0;
                            s_nxt.new_address_flag = 1'b0;
                            s_nxt.phase = PH_ZERO;
                        end
                        else
                        begin
                            s_nxt.gap_data_flag = 1'b1; // [R16]
                        end
                    end
                    if (toggle_gate)
                    begin
                        s_nxt.preamble_toggle = ~s_r.preamble_toggle; // [R15]
                    end
                    if (preamble_end)
                    begin
                        s_nxt.new_address_flag = 1'b0; // [R17]
                    end
                    if (data_time && (cnt == DATA_LAST_COUNT))
                    begin
                        s_nxt.gap_data_flag = 1'b0;
                    end
                    if (s_r.phase_cnt == WRITE_PHASE_PULSES - 9'h001)
                    begin
                        s_nxt.phase = PH_ZERO; // [R11]
                    end
                end
                PH_READ:
                begin
                    s_nxt.phase_cnt = s_r.phase_cnt + 9'h001;
                    if (s_r.phase_cnt == READ_PHASE_PULSES - 9'h001)
                    begin
                        s_nxt.phase = PH_ZERO;
                        s_nxt.read_enable_flag = 1'b0;
                    end
                end
            endcase
            if (!unit_address_on_channel && !s_r.new_address_flag)
            begin
                s_nxt.channel_connected = 1'b0; // [R10]
            end
        end
        if (apb_write)
        begin
            s_nxt.sector = pwdata[DGPS_SECTOR_W-1:0];
            s_nxt.new_address_flag = 1'b1;
        end
        s_nxt.read_enable_out = (s_nxt.phase == PH_ZERO) && s_nxt.read_enable_flag; // [R4]
        s_nxt.phase_bit_read = (s_nxt.phase == PH_READ);
        s_nxt.phase_bit_write = (s_nxt.phase == PH_WRITE); // [R11]
        s_nxt.data_request = (s_nxt.phase == PH_WRITE) && s_nxt.new_address_flag; // [R19]
        s_nxt.write_data_lines = '0;
        if (s_nxt.phase == PH_WRITE && s_nxt.gap_data_flag)
        begin
            if (s_nxt.new_address_flag)
            begin
                s_nxt.write_data_lines = {NT{s_nxt.preamble_toggle}}; // [R13] [R15]
            end
            else
            begin
                s_nxt.write_data_lines = disc_clk_pulse ? output_shift_bits : s_r.write_data_lines; // [R19]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '{phase: PH_ZERO, sector: DGPS_SECTOR_RST, default: '0};
        end
        else
        begin
            s_r <= s_nxt; // [R24]
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign prdata = s_r.prdata;
    assign data_request = s_r.data_request;
    assign channel_connected = s_r.channel_connected;
    assign error_flag = s_r.error_flag;
    assign read_enable = s_r.read_enable_out;
    assign phase_bit_read = s_r.phase_bit_read;
    assign phase_bit_write = s_r.phase_bit_write;
    assign write_data_lines = s_r.write_data_lines;

endmodule

// *** tb/dgps_checker.sv ***
// port-level assertions for the gap and preamble sequencer
`timescale 1ns/1ps
module dgps_checker
    import dgps_pkg::*;
#(
    parameter int NT = TRACKS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // disc and channel inputs
    input wire logic disc_clk_pulse,
    input wire logic clock_track_amp,
    input wire logic clock_cell_phase,
    input wire logic buffer_connect_command,
    input wire logic cmd_unit_match,
    input wire logic unit_address_on_channel,
    input wire logic band_write_locked,
    // watched outputs
    input wire logic data_request,
    input wire logic channel_connected,
    input wire logic error_flag,
    input wire logic read_enable,
    input wire logic phase_bit_read,
    input wire logic phase_bit_write,
    input wire logic [NT-1:0] write_data_lines,
    input wire logic [NT-1:0] track_write_flop
);
    logic [9:0] wcnt_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // disc pulses seen while in the write phase
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            wcnt_r <= 10'h000;
        else if (!phase_bit_write)
            wcnt_r <= 10'h000;
        else if (disc_clk_pulse)
            wcnt_r <= wcnt_r + 10'h001;
    end
    a_write_len: assert property ($fell(phase_bit_write) |-> wcnt_r == 10'h196 || (wcnt_r == 10'h001 && error_flag))
        else $error("write phase length wrong");
    a_protect_abort: assert property (disc_clk_pulse && phase_bit_write && band_write_locked |=>
        error_flag && !channel_connected && !phase_bit_write) else $error("no protect abort");
    a_protect_quiet: assert property (phase_bit_write && band_write_locked |-> write_data_lines == '0)
        else $error("preamble on locked band");
    a_phase_excl: assert property (!(phase_bit_read && phase_bit_write))
        else $error("both phase bits set");
    a_preamble_lines: assert property (data_request |-> write_data_lines == '0 || write_data_lines == '1)
        else $error("preamble tracks differ");
    a_disc_paced: assert property ($changed(write_data_lines) |-> $past(disc_clk_pulse))
        else $error("lines moved off pulse");
    a_connect_set: assert property (disc_clk_pulse && !phase_bit_read && !phase_bit_write && buffer_connect_command
        && cmd_unit_match |=> channel_connected && !error_flag) else $error("connect command not taken");
    a_track_toggle: assert property (clock_track_amp && phase_bit_write |=> track_write_flop ==
        ($past(track_write_flop) ^ ($past(clock_cell_phase) ? {NT{1'b1}} : $past(write_data_lines))))
        else $error("track flop toggle wrong");
    a_read_en_rise: assert property ($rose(read_enable) |-> $past(disc_clk_pulse) && !phase_bit_write)
        else $error("read enable rose off pulse");
    a_drop_disconnect: assert property (disc_clk_pulse && phase_bit_write && !data_request
        && !unit_address_on_channel |=> !channel_connected) else $error("drop kept connected");
    a_write_clr_ren: assert property ($rose(phase_bit_write) |-> !read_enable)
        else $error("read enable on write entry");
endmodule
bind dgps_sequencer dgps_checker #(.NT(NT)) chk_u (.clk_sys(clk_sys), .rst(rst), .disc_clk_pulse(disc_clk_pulse),
    .clock_track_amp(clock_track_amp), .clock_cell_phase(clock_cell_phase),
    .buffer_connect_command(buffer_connect_command), .cmd_unit_match(cmd_unit_match),
    .unit_address_on_channel(unit_address_on_channel), .band_write_locked(band_write_locked),
    .data_request(data_request), .channel_connected(channel_connected), .error_flag(error_flag),
    .read_enable(read_enable), .phase_bit_read(phase_bit_read), .phase_bit_write(phase_bit_write),
    .write_data_lines(write_data_lines), .track_write_flop(track_write_flop));

// *** tb/dgps_partner.sv ***
// far-side model: disc timing, sector track and channel connect
`timescale 1ns/1ps
module dgps_partner
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bench control
    input wire logic arm,
    input wire logic [5:0] target,
    input wire logic [4:0] conn_at,
    // disc timing
    output logic disc_clk_pulse,
    output logic clock_track_amp,
    output logic clock_cell_phase,
    output logic compare_window,
    output logic [5:0] current_sector,
    // channel
    output logic buffer_connect_command,
    output logic cmd_unit_match
);
    logic [1:0] cyc_r;
    logic [4:0] gap_r;
    // one disc clock per four system clocks, clock cell then data cell
    assign disc_clk_pulse = cyc_r == 2'h0;
    assign clock_track_amp = cyc_r[0];
    assign clock_cell_phase = !cyc_r[1];
    assign compare_window = !cyc_r[1];
    // connect sent on the chosen gap pulse
    assign buffer_connect_command = disc_clk_pulse && gap_r == conn_at;
    assign cmd_unit_match = buffer_connect_command;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cyc_r <= 2'h0;
            gap_r <= 5'h1F;
            current_sector <= 6'h00;
        end
        else
        begin
            cyc_r <= cyc_r + 2'h1;
            if (cyc_r == 2'h3)
                current_sector <= current_sector + 6'h01;
            if (disc_clk_pulse && arm && current_sector == target)
                gap_r <= 5'h01;
            else if (disc_clk_pulse && gap_r != 5'h1F)
                gap_r <= gap_r + 5'h01;
        end
    end
endmodule

// *** tb/dgps_sequencer_tb.sv ***
// self-checking bench for the gap and preamble sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module dgps_sequencer_tb
    import dgps_pkg::*;
;
    localparam logic [9:0] PRE = 10'h154;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arm = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, disc_clk_pulse, clock_track_amp, clock_cell_phase, compare_window;
    logic buffer_connect_command, cmd_unit_match, data_request, channel_connected, error_flag;
    logic read_enable, phase_bit_read, phase_bit_write;
    logic unit_address_on_channel = 1'b1, direction_bit = 1'b0, band_write_locked = 1'b0;
    logic [3:0] output_shift_bits = 4'h0, sb, write_data_lines, track_write_flop;
    logic [5:0] current_sector, target = 6'h00;
    logic [4:0] conn_at = 5'h05;
    int mismatches = 0, samples_checked = 0, cyc_cnt = 0;

    dgps_sequencer dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .disc_clk_pulse, .clock_track_amp, .clock_cell_phase, .compare_window, .current_sector,
        .buffer_connect_command, .cmd_unit_match, .unit_address_on_channel, .direction_bit, .output_shift_bits,
        .data_request, .channel_connected, .error_flag, .band_write_locked, .read_enable, .phase_bit_read,
        .phase_bit_write, .write_data_lines, .track_write_flop);
    dgps_partner partner_u (.clk_sys, .rst, .arm, .target, .conn_at, .disc_clk_pulse, .clock_track_amp,
        .clock_cell_phase, .compare_window, .current_sector, .buffer_connect_command, .cmd_unit_match);

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        if (disc_clk_pulse)
            output_shift_bits <= 4'($urandom);
        cyc_cnt++;
        if (cyc_cnt == 30000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("TB: checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            mismatches++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // take a disc pulse edge, check one edge later
    task automatic pulse();
        while (disc_clk_pulse !== 1'b1)
            @(posedge clk_sys);
        sb = output_shift_bits;
        @(posedge clk_sys);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        `CHK({channel_connected, error_flag, read_enable, data_request, phase_bit_read, phase_bit_write, write_data_lines}, 10'h000)
    endtask

    task automatic run(input logic dir, input logic lock, input logic [4:0] ca, input int drop);
        int g;
        logic [5:0] tgt;
        logic [3:0] el;
        tgt = 6'(current_sector + 6'h08 + 6'($urandom_range(31, 0)));
        direction_bit <= dir;
        band_write_locked <= lock;
        unit_address_on_channel <= 1'b1;
        conn_at <= ca;
        target <= tgt;
        arm <= 1'b1;
        apb(1'b1, DGPS_ADDR_OFS, {26'h0, tgt}, rd, err);
        g = 0;
        do
        begin
            pulse();
            g++;
        end
        while (current_sector !== tgt && g < 70);
        arm <= 1'b0;
        for (g = 1; g <= 13; g++)
        begin
            pulse();
            if (g < 13)
                `CHK(read_enable, 1'(g >= 3))
            `CHK(channel_connected, 1'(g >= ca))
            if (g >= ca)
                `CHK(error_flag, 1'b0)
        end
        if (ca > 5'h0D)
        begin
            `CHK({phase_bit_read, phase_bit_write}, 2'b00)
            apb(1'b0, DGPS_STATUS_OFS, 32'h0, rd, err);
            `CHK(rd[1:0], 2'b01)
            pulse();
            `CHK(channel_connected, 1'b1)
        end
        else
        begin
            `CHK(read_enable, 1'b0)
            `CHK({phase_bit_read, phase_bit_write}, {!dir, dir})
            for (g = 1; g <= (lock ? 1 : 406); g++)
            begin
                if (g == drop)
                    unit_address_on_channel <= 1'b0;
                pulse();
                if (g <= 10)
                    el = {4{PRE[10 - g]}};
                else if (g <= 394)
                    el = sb;
                else
                    el = 4'h0;
                if (lock)
                    `CHK({error_flag, channel_connected, phase_bit_write, write_data_lines}, 7'h40)
                else if (dir)
                begin
                    `CHK(phase_bit_write, 1'(g < 406))
                    `CHK(write_data_lines, el)
                    `CHK(data_request, 1'(g <= 10))
                    `CHK(channel_connected, 1'(drop == 0 || g < drop))
                end
                else
                    `CHK({phase_bit_read, read_enable}, {1'(g < 406), 1'b0})
                if (dir && !lock && g == 12)
                begin
                    apb(1'b0, DGPS_STATUS_OFS, 32'h0, rd, err);
                    `CHK({rd[4], rd[1:0]}, 3'b010)
                end
            end
        end
        $display("TB: run %0d %0d %0d done", dir, lock, ca);
    endtask

    initial
    begin
        void'($urandom(25480));
        do_reset();
        apb(1'b0, DGPS_ADDR_OFS, 32'h0, rd, err);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, DGPS_STATUS_OFS, 32'hFFFF_FFFF, rd, err);
        apb(1'b0, DGPS_STATUS_OFS, 32'h0, rd, err);
        `CHK({err, rd}, 33'h0_0000_0000)
        apb(1'b0, 12'h008, 32'h0, rd, err);
        `CHK({err, rd}, 33'h1_0000_0000)
        $display("TB: register test done");
        run(1'b1, 1'b0, 5'h05, 200);
        run(1'b1, 1'b1, 5'h0C, 0);
        run(1'b0, 1'b0, 5'h03, 0);
        do_reset();
        run(1'b1, 1'b0, 5'h0E, 0);
        print_verdict();
    end
endmodule
